// [core/csb_defs.svh]
// Constants for the processor sideband, NMI and reset control block
// Behaviour
// - System-error pulse sets status bit 7 while disable bit 2 is zero.
// - Channel-check line sets status bit 6 while disable bit 3 is zero.
// - Bit 5 reads live counter 2 output.
// - Bit 4 toggles at the legacy refresh rate.
// - Disable bit one clears and blocks its source; zero enables it.
// - Speaker low when bit 1 zero, else follows counter 2 output.
// - Mask bit 7 of port 70h blocks all NMIs; resets to 80h.
// - Bits 6:0 of port 70h go to the clock as RAM index.
// - Index write-only at 70h unless alternate access; alias 74h reads all.
// - Address mask output comes from external gate OR fast gate bit.
// - Fast gate bit is set whenever init output becomes active.
// - Init-request bit rising holds init active 16 clocks.
// - Write to error port drives ignore output if numeric IRQ13 pending.
// - Numeric error input makes IRQ13 only while its enable is one.
// - Reset bit rising with hard select asserts PCI reset for 1 ms.
// - Reset bit rising with soft select asserts init for 16 clocks.
// - Full-reset bit plus hard select plus reset bit rising does full reset.
`ifndef CSB_DEFS_SVH
`define CSB_DEFS_SVH
`define CSB_ADDR_W 16
`define CSB_OFF_NMI_STATUS_CONTROL 16'h0061
`define CSB_OFF_NMI_IDX 16'h0070
`define CSB_OFF_NMI_IDX_ALIAS 16'h0074
`define CSB_OFF_FAST_INIT 16'h0092
`define CSB_OFF_NUM_ERR 16'h00f0
`define CSB_OFF_RST_CTL 16'h0cf9
`define CSB_RST_NMI_STATUS_CONTROL 8'h00
`define CSB_RST_NMI_IDX 8'h80
`define CSB_RST_FAST_INIT 8'h00
`define CSB_RST_RST_CTL 8'h00
`define CSB_SC_SYSERR_STS 7
`define CSB_SC_CHCHK_STS 6
`define CSB_SC_CNT2_OUT 5
`define CSB_SC_REFRESH 4
`define CSB_SC_CHCHK_DIS 3
`define CSB_SC_SYSERR_DIS 2
`define CSB_SC_SPEAKER 1
`define CSB_SC_CNT2_GATE 0
`define CSB_IDX_MASK 7
`define CSB_FI_FAST_GATE 1
`define CSB_FI_INIT_REQ 0
`define CSB_RC_FULL 3
`define CSB_RC_CPU 2
`define CSB_RC_HARD 1
`define CSB_CLK_MHZ 125
`define CSB_INIT_CLKS 16
`define CSB_HARD_RST_US 1000
`define CSB_HARD_RST_CLKS (`CSB_HARD_RST_US * `CSB_CLK_MHZ)
`define CSB_REFRESH_NS 15000
`define CSB_REFRESH_CLKS (`CSB_REFRESH_NS / 8)
`endif

// [core/csb_pkg.sv]
// Types for the processor sideband block
package csb_pkg;
    typedef enum logic [2:0] {
        CSB_RST_IDLE = 3'b001,
        CSB_RST_INIT = 3'b010,
        CSB_RST_HARD = 3'b100
    } csb_rst_state_e;
    typedef logic [7:0] csb_byte_t;
endpackage : csb_pkg

// [core/csb_pulse_timer.sv]
// Fixed-length pulse stretcher used for init and PCI reset
`timescale 1ns/1ns
`include "csb_defs.svh"
`default_nettype none
module csb_pulse_timer #(
    parameter int unsigned LEN = 16
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic start_in,
    output logic active_out
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;

    // A start during a running pulse restarts the full length
    always_comb begin
        cnt_nxt = cnt_r;
        if (start_in) begin
            cnt_nxt = LEN;
        end else if (cnt_r != 32'h0000_0000) begin
            cnt_nxt = cnt_r - 32'h0000_0001;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cnt_r <= 32'h0000_0000;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign active_out = (cnt_r != 32'h0000_0000);
endmodule : csb_pulse_timer
`default_nettype wire

// [core/csb_sideband.sv]
// Processor sideband, NMI collection and reset control behind fixed I/O ports
`timescale 1ns/1ns
`include "csb_defs.svh"
`default_nettype none
module csb_sideband
    import csb_pkg::*;
#(
    parameter int unsigned HARD_RST_CLKS = `CSB_HARD_RST_CLKS
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [15:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [7:0] io_wdata_in,
    output logic [7:0] io_rdata_out,
    output logic io_hit_out,
    input wire logic alt_access_in,
    input wire logic syserr_pulse_in,
    input wire logic channel_check_line_in,
    input wire logic counter2_out_in,
    input wire logic ext_addr_gate_in,
    input wire logic numeric_error_in,
    input wire logic numeric_error_irq_enable_in,
    output logic counter2_gate_out,
    output logic speaker_out,
    output logic [6:0] clock_ram_index_out,
    output logic nmi_out,
    output logic addr_bit_mask_out,
    output logic init_out,
    output logic ignore_numeric_err_out,
    output logic pci_reset_out,
    output logic full_reset_out,
    output logic resume_reset_out
);
    localparam int unsigned INIT_CLKS = `CSB_INIT_CLKS;
    localparam int unsigned REF_CLKS = `CSB_REFRESH_CLKS;

    // Decode shared by the read and the write paths
    function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
        hit = (a == off);
    endfunction : hit

    logic wr_sc;
    logic wr_idx;
    logic wr_fi;
    logic wr_ne;
    logic wr_rc;
    assign wr_sc = io_wr_in && hit(io_addr_in, `CSB_OFF_NMI_STATUS_CONTROL);
    assign wr_idx = io_wr_in && (hit(io_addr_in, `CSB_OFF_NMI_IDX) || hit(io_addr_in, `CSB_OFF_NMI_IDX_ALIAS));
    assign wr_fi = io_wr_in && hit(io_addr_in, `CSB_OFF_FAST_INIT);
    assign wr_ne = io_wr_in && hit(io_addr_in, `CSB_OFF_NUM_ERR);
    assign wr_rc = io_wr_in && hit(io_addr_in, `CSB_OFF_RST_CTL);

    // Register state
    logic [3:0] sc_ctl_r;
    logic [3:0] sc_ctl_nxt;
    logic syserr_sts_r;
    logic syserr_sts_nxt;
    logic chchk_sts_r;
    logic chchk_sts_nxt;
    csb_byte_t idx_r;
    csb_byte_t idx_nxt;
    logic fast_gate_r;
    logic fast_gate_nxt;
    logic init_req_r;
    logic init_req_nxt;
    logic [2:0] rc_r;
    logic [2:0] rc_nxt;
    logic irq13_r;
    logic irq13_nxt;
    logic ignore_numeric_err_out_r;
    logic ignore_numeric_err_out_nxt;
    logic refresh_r;
    logic refresh_nxt;
    logic [15:0] ref_cnt_r;
    logic [15:0] ref_cnt_nxt;
    logic init_active;
    logic init_active_d_r;
    logic pci_rst_active;
    logic init_start;
    logic hard_start;
    logic full_r;
    logic full_nxt;
    csb_rst_state_e rst_state_r;
    csb_rst_state_e rst_state_nxt;

    // Edge of the reset-processor bit, resolved against the select bits being written
    logic cpu_rise;
    logic hard_sel;
    assign cpu_rise = wr_rc && io_wdata_in[`CSB_RC_CPU] && !rc_r[`CSB_RC_CPU - 1];
    assign hard_sel = io_wdata_in[`CSB_RC_HARD];
    assign init_start = (wr_fi && io_wdata_in[`CSB_FI_INIT_REQ] && !init_req_r)
        || (cpu_rise && !hard_sel);
    assign hard_start = cpu_rise && hard_sel;

    // NMI status and control bits
    always_comb begin
        sc_ctl_nxt = sc_ctl_r;
        if (wr_sc) begin
            sc_ctl_nxt = io_wdata_in[3:0]; // Upper bits are ignored whatever value is written
        end
        syserr_sts_nxt = syserr_sts_r;
        chchk_sts_nxt = chchk_sts_r;
        // A disable bit written in this cycle clears the status even against a source pulse
        if (sc_ctl_nxt[`CSB_SC_SYSERR_DIS]) begin
            syserr_sts_nxt = 1'b0;
        end else if (syserr_pulse_in) begin
            syserr_sts_nxt = 1'b1;
        end
        if (sc_ctl_nxt[`CSB_SC_CHCHK_DIS]) begin
            chchk_sts_nxt = 1'b0;
        end else if (channel_check_line_in) begin
            chchk_sts_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            sc_ctl_r <= 4'h0;
            syserr_sts_r <= 1'b0;
            chchk_sts_r <= 1'b0;
        end else begin
            sc_ctl_r <= sc_ctl_nxt;
            syserr_sts_r <= syserr_sts_nxt;
            chchk_sts_r <= chchk_sts_nxt;
        end
    end

    // Refresh toggle, a free divider standing in for the old refresh timer
    always_comb begin
        ref_cnt_nxt = ref_cnt_r + 16'h0001;
        refresh_nxt = refresh_r;
        if (ref_cnt_r == 16'(REF_CLKS - 1)) begin
            ref_cnt_nxt = 16'h0000;
            refresh_nxt = !refresh_r;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ref_cnt_r <= 16'h0000;
            refresh_r <= 1'b0;
        end else begin
            ref_cnt_r <= ref_cnt_nxt;
            refresh_r <= refresh_nxt;
        end
    end

    // Mask/index, fast gate/init and reset control registers
    always_comb begin
        idx_nxt = idx_r;
        fast_gate_nxt = fast_gate_r;
        init_req_nxt = init_req_r;
        rc_nxt = rc_r;
        if (wr_idx) begin
            idx_nxt = io_wdata_in;
        end
        if (wr_fi) begin
            fast_gate_nxt = io_wdata_in[`CSB_FI_FAST_GATE];
            init_req_nxt = io_wdata_in[`CSB_FI_INIT_REQ];
        end
        if (init_active && !init_active_d_r) begin
            fast_gate_nxt = 1'b1; // Hardware set wins over a same-cycle write
        end
        if (wr_rc) begin
            rc_nxt = io_wdata_in[3:1];
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            idx_r <= `CSB_RST_NMI_IDX; // NMIs masked out of reset
            fast_gate_r <= 1'b0;
            init_req_r <= 1'b0;
            rc_r <= 3'b000;
            init_active_d_r <= 1'b0;
        end else begin
            idx_r <= idx_nxt;
            fast_gate_r <= fast_gate_nxt;
            init_req_r <= init_req_nxt;
            rc_r <= rc_nxt;
            init_active_d_r <= init_active;
        end
    end

    // Numeric error: IRQ13 latch and the ignore output
    always_comb begin
        irq13_nxt = irq13_r;
        ignore_numeric_err_out_nxt = ignore_numeric_err_out_r;
        if (numeric_error_in && numeric_error_irq_enable_in) begin
            irq13_nxt = 1'b1;
        end else if (!numeric_error_in) begin
            irq13_nxt = 1'b0;
            ignore_numeric_err_out_nxt = 1'b0; // Error gone, stop ignoring
        end
        if (wr_ne && irq13_r) begin
            ignore_numeric_err_out_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            irq13_r <= 1'b0;
            ignore_numeric_err_out_r <= 1'b0;
        end else begin
            irq13_r <= irq13_nxt;
            ignore_numeric_err_out_r <= ignore_numeric_err_out_nxt;
        end
    end

    // Reset sequencer: tracks which kind of reset pulse is in flight
    always_comb begin
        rst_state_nxt = rst_state_r;
        full_nxt = full_r;
        case (rst_state_r)
            CSB_RST_IDLE: begin
                if (hard_start) begin
                    rst_state_nxt = CSB_RST_HARD;
                    full_nxt = io_wdata_in[`CSB_RC_FULL];
                end else if (init_start) begin
                    rst_state_nxt = CSB_RST_INIT;
                end
            end
            CSB_RST_INIT: begin
                if (hard_start) begin
                    rst_state_nxt = CSB_RST_HARD;
                    full_nxt = io_wdata_in[`CSB_RC_FULL];
                end else if (!init_active && !init_start) begin
                    rst_state_nxt = CSB_RST_IDLE;
                end
            end
            CSB_RST_HARD: begin
                if (hard_start) begin
                    full_nxt = io_wdata_in[`CSB_RC_FULL]; // A new hard reset restarts the pulse with its own kind
                end else if (!pci_rst_active) begin
                    rst_state_nxt = CSB_RST_IDLE;
                    full_nxt = 1'b0;
                end
            end
            default: begin
                rst_state_nxt = CSB_RST_IDLE;
                full_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rst_state_r <= CSB_RST_IDLE;
            full_r <= 1'b0;
        end else begin
            rst_state_r <= rst_state_nxt;
            full_r <= full_nxt;
        end
    end

    // Pulse timers for init (16 clocks) and PCI reset (1 ms)
    csb_pulse_timer #(.LEN(INIT_CLKS)) u_init_timer (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .start_in(init_start),
        .active_out(init_active)
    );

    csb_pulse_timer #(.LEN(HARD_RST_CLKS)) u_hard_timer (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .start_in(hard_start),
        .active_out(pci_rst_active)
    );

    // Read mux; the index at 70h hides unless alternate access is on
    always_comb begin
        io_rdata_out = 8'h00;
        io_hit_out = 1'b1;
        if (hit(io_addr_in, `CSB_OFF_NMI_STATUS_CONTROL)) begin
            io_rdata_out = {syserr_sts_r, chchk_sts_r, counter2_out_in, refresh_r, sc_ctl_r};
        end else if (hit(io_addr_in, `CSB_OFF_NMI_IDX)) begin
            io_rdata_out = alt_access_in ? idx_r : {idx_r[7], 7'h00};
        end else if (hit(io_addr_in, `CSB_OFF_NMI_IDX_ALIAS)) begin
            io_rdata_out = idx_r;
        end else if (hit(io_addr_in, `CSB_OFF_FAST_INIT)) begin
            io_rdata_out = {6'h00, fast_gate_r, init_req_r};
        end else if (hit(io_addr_in, `CSB_OFF_RST_CTL)) begin
            io_rdata_out = {4'h0, rc_r, 1'b0};
        end else begin
            io_hit_out = 1'b0; // Write-only 0F0h and unmapped ports read zero
        end
        if (!io_rd_in) begin
            io_rdata_out = 8'h00;
        end
    end

    // Sideband outputs
    assign counter2_gate_out = sc_ctl_r[`CSB_SC_CNT2_GATE];
    assign speaker_out = sc_ctl_r[`CSB_SC_SPEAKER] & counter2_out_in;
    assign clock_ram_index_out = idx_r[6:0];
    assign nmi_out = !idx_r[`CSB_IDX_MASK] && (syserr_sts_r || chchk_sts_r);
    assign addr_bit_mask_out = ext_addr_gate_in | fast_gate_r;
    assign init_out = init_active;
    assign ignore_numeric_err_out = ignore_numeric_err_out_r;
    assign pci_reset_out = pci_rst_active;
    assign full_reset_out = pci_rst_active && full_r;
    assign resume_reset_out = pci_rst_active;
endmodule : csb_sideband
`default_nettype wire

// [testbench/csb_sideband_chk.sv]
// Assertion checker for the processor sideband block
`timescale 1ns/1ns
`default_nettype none
module csb_sideband_chk #(
    parameter int unsigned HARD_RST_CLKS = 20
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [15:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic [7:0] io_wdata_in,
    input wire logic counter2_out_in,
    input wire logic ext_addr_gate_in,
    input wire logic numeric_error_in,
    input wire logic speaker_out,
    input wire logic nmi_out,
    input wire logic addr_bit_mask_out,
    input wire logic init_out,
    input wire logic ignore_numeric_err_out,
    input wire logic pci_reset_out,
    input wire logic full_reset_out,
    input wire logic resume_reset_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    logic [31:0] ilen_r, ilen_nxt, plen_r, plen_nxt;
    // Run lengths of the timed pulses; a restart would need its own figure
    always_comb begin
        ilen_nxt = init_out ? ilen_r + 32'h0000_0001 : 32'h0000_0000;
        plen_nxt = pci_reset_out ? plen_r + 32'h0000_0001 : 32'h0000_0000;
    end
    always_ff @(posedge clock_in) begin
        ilen_r <= rst_in ? 32'h0000_0000 : ilen_nxt;
        plen_r <= rst_in ? 32'h0000_0000 : plen_nxt;
    end
    sequence s_port_wr(logic [15:0] port);
        io_wr_in && io_addr_in == port;
    endsequence
    a_speaker_gate:
        assert property (speaker_out |-> counter2_out_in) else $error("speaker high while counter low");
    a_addr_or:
        assert property (ext_addr_gate_in |-> addr_bit_mask_out) else $error("address mask ignores gate");
    a_fast_set:
        assert property ($rose(init_out) |-> ##[0:2] addr_bit_mask_out) else $error("fast gate not set");
    a_init_len:
        assert property ($fell(init_out) |-> ilen_r == 32'h0000_0010) else $error("init length wrong");
    a_hard_len:
        assert property ($fell(pci_reset_out) |-> plen_r == HARD_RST_CLKS) else $error("hard reset length wrong");
    a_resume_same:
        assert property (resume_reset_out == pci_reset_out) else $error("resume reset differs");
    a_full_within:
        assert property (full_reset_out |-> pci_reset_out) else $error("full reset outside pci reset");
    a_nmi_mask:
        assert property (s_port_wr(16'h0070) ##0 io_wdata_in[7] |=> !nmi_out) else $error("masked nmi seen");
    a_ignore_cause:
        assert property ($rose(ignore_numeric_err_out) |-> $past(io_wr_in) && $past(io_addr_in) == 16'h00f0
            && $past(numeric_error_in)) else $error("ignore output without cause");
endmodule : csb_sideband_chk
bind csb_sideband csb_sideband_chk #(.HARD_RST_CLKS(HARD_RST_CLKS)) i_csb_sideband_chk (
    .clock_in(clock_in), .rst_in(rst_in), .io_addr_in(io_addr_in), .io_wr_in(io_wr_in),
    .io_wdata_in(io_wdata_in), .counter2_out_in(counter2_out_in), .ext_addr_gate_in(ext_addr_gate_in),
    .numeric_error_in(numeric_error_in), .speaker_out(speaker_out), .nmi_out(nmi_out),
    .addr_bit_mask_out(addr_bit_mask_out), .init_out(init_out), .ignore_numeric_err_out(ignore_numeric_err_out),
    .pci_reset_out(pci_reset_out), .full_reset_out(full_reset_out), .resume_reset_out(resume_reset_out)
);
`default_nettype wire

// [testbench/csb_host_model.sv]
// Interval timer and PCI agent model on the far side of the sideband pins
`timescale 1ns/1ns
`default_nettype none
module csb_host_model (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic counter2_gate_in,
    input wire logic serr_req_in,
    output logic counter2_out_out,
    output logic syserr_pulse_out
);
    logic [1:0] div_r, div_nxt;
    logic out_r, out_nxt, req_r, req_nxt;
    // Counter 2 square wave, toggling every fourth clock while gated, low otherwise
    always_comb begin
        div_nxt = counter2_gate_in ? div_r + 2'h1 : 2'h0;
        out_nxt = counter2_gate_in ? out_r ^ (div_r == 2'h3) : 1'h0;
        req_nxt = serr_req_in;
    end
    always_ff @(posedge clock_in) begin
        div_r <= rst_in ? 2'h0 : div_nxt;
        out_r <= rst_in ? 1'h0 : out_nxt;
        req_r <= rst_in ? 1'h0 : req_nxt;
    end
    // One clock of error pulse per request, however long the request is held
    assign counter2_out_out = out_r;
    assign syserr_pulse_out = serr_req_in && !req_r;
endmodule : csb_host_model
`default_nettype wire

// [testbench/csb_sideband_tb.sv]
// Self-checking bench for the processor sideband block
`timescale 1ns/1ns
`include "csb_defs.svh"
`default_nettype none
module csb_sideband_tb;
    localparam int HARD = 20;
    logic clock_in = 1'h0, rst_in = 1'h1, io_wr_in = 1'h0, io_rd_in = 1'h0, alt_access_in = 1'h0;
    logic serr_req = 1'h0, channel_check_line_in = 1'h0, ext_addr_gate_in = 1'h0;
    logic numeric_error_in = 1'h0, numeric_error_irq_enable_in = 1'h0;
    logic [15:0] io_addr_in = 16'h0000;
    logic [7:0] io_wdata_in = 8'h00, io_rdata_out, r1;
    logic [6:0] clock_ram_index_out;
    logic io_hit_out, syserr_pulse_in, counter2_out_in, counter2_gate_out, speaker_out, nmi_out;
    logic addr_bit_mask_out, init_out, ignore_numeric_err_out, pci_reset_out, full_reset_out, resume_reset_out;
    int err_total = 0, total_checks = 0, ilen = 0, plen = 0, flen = 0;
    csb_sideband #(.HARD_RST_CLKS(HARD)) i_csb_sideband (
        .clock_in(clock_in), .rst_in(rst_in), .io_addr_in(io_addr_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in),
        .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out), .io_hit_out(io_hit_out),
        .alt_access_in(alt_access_in), .syserr_pulse_in(syserr_pulse_in),
        .channel_check_line_in(channel_check_line_in), .counter2_out_in(counter2_out_in),
        .ext_addr_gate_in(ext_addr_gate_in), .numeric_error_in(numeric_error_in),
        .numeric_error_irq_enable_in(numeric_error_irq_enable_in), .counter2_gate_out(counter2_gate_out),
        .speaker_out(speaker_out), .clock_ram_index_out(clock_ram_index_out), .nmi_out(nmi_out),
        .addr_bit_mask_out(addr_bit_mask_out), .init_out(init_out), .ignore_numeric_err_out(ignore_numeric_err_out),
        .pci_reset_out(pci_reset_out), .full_reset_out(full_reset_out), .resume_reset_out(resume_reset_out));
    csb_host_model i_csb_host_model (.clock_in(clock_in), .rst_in(rst_in), .counter2_gate_in(counter2_gate_out),
        .serr_req_in(serr_req), .counter2_out_out(counter2_out_in), .syserr_pulse_out(syserr_pulse_in));
    initial forever #4 clock_in = ~clock_in;
    // High cycles of the timed outputs; scenarios clear ilen and plen before a trigger, flen is never cleared
    always @(posedge clock_in) begin
        ilen += int'(init_out);
        plen += int'(pci_reset_out);
        flen += int'(full_reset_out);
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic chb(input string what, input logic seen, input logic exp);
        check(what, {7'h00, seen}, {7'h00, exp});
    endtask : chb
    task automatic wt(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : wt
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock_in);
        #1 io_addr_in = a;
        io_wdata_in = d;
        io_wr_in = 1'h1;
        wt(1);
        io_wr_in = 1'h0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clock_in);
        #1 io_addr_in = a;
        io_rd_in = 1'h1;
        #2 check("read", io_rdata_out, exp);
        wt(1);
        io_rd_in = 1'h0;
    endtask : rd
    task automatic serr_once;
        serr_req = 1'h1;
        wt(2);
        serr_req = 1'h0;
    endtask : serr_once
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    // Watchdog well beyond the few thousand cycles the sequence needs
    initial begin
        #(8 * 10000);
        err_total++;
        complete_run;
    end
    initial begin
        wt(8);
        rst_in = 1'h0;
        rd(16'h0061, 8'h00);
        rd(16'h0074, 8'h80);
        chb("hit", io_hit_out, 1'h1);
        rd(16'h0070, 8'h80);
        rd(16'h0092, 8'h00);
        rd(16'h0cf9, 8'h00);
        rd(16'h00f0, 8'h00);
        chb("hit", io_hit_out, 1'h0);
        wr(16'h0070, 8'h35);
        check("index", {1'h0, clock_ram_index_out}, 8'h35);
        rd(16'h0070, 8'h00);
        alt_access_in = 1'h1;
        rd(16'h0070, 8'h35);
        alt_access_in = 1'h0;
        rd(16'h0074, 8'h35);
        serr_once;
        rd(16'h0061, 8'h80);
        chb("nmi", nmi_out, 1'h1);
        wr(16'h0070, 8'hb5);
        chb("nmi", nmi_out, 1'h0);
        wr(16'h0070, 8'h35);
        chb("nmi", nmi_out, 1'h1);
        wr(16'h0061, 8'h04);
        chb("nmi", nmi_out, 1'h0);
        serr_once;
        rd(16'h0061, 8'h04);
        wr(16'h0061, 8'h00);
        channel_check_line_in = 1'h1;
        wt(2);
        rd(16'h0061, 8'h40);
        chb("nmi", nmi_out, 1'h1);
        wr(16'h0061, 8'h00);
        wr(16'h0061, 8'h08);
        channel_check_line_in = 1'h0;
        rd(16'h0061, 8'h08);
        chb("nmi", nmi_out, 1'h0);
        wr(16'h0061, 8'h03);
        chb("gate", counter2_gate_out, 1'h1);
        io_addr_in = 16'h0061;
        io_rd_in = 1'h1;
        for (int i = 0; i < 12; i++) begin
            wt(1);
            chb("speaker", speaker_out, counter2_out_in);
            chb("mirror", io_rdata_out[5], counter2_out_in);
        end
        // Find a toggle, then prove the next one comes exactly one period later
        r1 = io_rdata_out;
        for (int i = 0; i < `CSB_REFRESH_CLKS && io_rdata_out[4] === r1[4]; i++) begin
            wt(1);
        end
        r1 = io_rdata_out;
        wt(`CSB_REFRESH_CLKS - 1);
        chb("refresh hold", io_rdata_out[4], r1[4]);
        wt(1);
        chb("refresh", io_rdata_out[4], ~r1[4]);
        io_rd_in = 1'h0;
        wr(16'h0061, 8'h01);
        for (int i = 0; i < 8; i++) begin
            wt(1);
            chb("speaker", speaker_out, 1'h0);
        end
        ext_addr_gate_in = 1'h1;
        #1 chb("a20", addr_bit_mask_out, 1'h1);
        ext_addr_gate_in = 1'h0;
        #1 chb("a20", addr_bit_mask_out, 1'h0);
        ilen = 0;
        wr(16'h0092, 8'h01);
        wt(20);
        check("init", 8'(ilen), 8'(`CSB_INIT_CLKS));
        rd(16'h0092, 8'h03);
        chb("a20", addr_bit_mask_out, 1'h1);
        wr(16'h0092, 8'h00);
        ilen = 0;
        plen = 0;
        wr(16'h0cf9, 8'h04);
        wt(20);
        check("soft", 8'(ilen), 8'(`CSB_INIT_CLKS));
        check("soft pci", 8'(plen), 8'h00);
        wr(16'h0cf9, 8'h00);
        plen = 0;
        wr(16'h0cf9, 8'h06);
        wt(HARD + 4);
        check("hard", 8'(plen), 8'(HARD));
        check("full", 8'(flen), 8'h00);
        wr(16'h0cf9, 8'h00);
        plen = 0;
        wr(16'h0cf9, 8'h0e);
        wt(HARD + 4);
        check("full", 8'(flen), 8'(HARD));
        check("full pci", 8'(plen), 8'(HARD));
        numeric_error_in = 1'h1;
        wt(2);
        wr(16'h00f0, 8'h00);
        wt(1);
        chb("ignore", ignore_numeric_err_out, 1'h0);
        numeric_error_in = 1'h0;
        numeric_error_irq_enable_in = 1'h1;
        wt(2);
        numeric_error_in = 1'h1;
        wt(2);
        wr(16'h00f0, 8'h5a);
        wt(1);
        chb("ignore", ignore_numeric_err_out, 1'h1);
        numeric_error_in = 1'h0;
        wt(3);
        chb("ignore", ignore_numeric_err_out, 1'h0);
        complete_run;
    end
endmodule : csb_sideband_tb
`default_nettype wire
